// [pkg/mhs_pkg.sv]
// Package for the hot-swap sequencer and indicator block
package mhs_pkg;
   // Register map, byte addresses of 32-bit words
   localparam int ADDR_W = 5;
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_CMD = 5'h04;
   localparam logic [4:0] REG_STATUS = 5'h08;
   localparam logic [4:0] REG_IRQ_STAT = 5'h0c;
   localparam logic [4:0] REG_IRQ_EN = 5'h10;
   localparam logic [4:0] REG_IRQ_CLR = 5'h14;
   localparam logic [4:0] REG_PORT = 5'h18;
   // Control register fields
   localparam int CTRL_OOS_APP_EN = 0;
   localparam int CTRL_OOS_APP_ON = 1;
   localparam int CTRL_HLT_APP_EN = 2;
   localparam int CTRL_HLT_APP_AMBER = 3;
   localparam int CTRL_PWR_DENIED = 4;
   localparam int CTRL_W = 5;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   // Command register fields, self-clearing
   localparam int CMD_QUIESCE = 0;
   localparam int CMD_REJECT = 1;
   localparam int CMD_ACT_REQ = 2;
   localparam int CMD_ACT_GRANT = 3;
   // Status register fields
   localparam int STAT_HS_LSB = 0;
   localparam int STAT_PWR = 6;
   localparam int STAT_RUN = 7;
   localparam int STAT_HOLD = 8;
   localparam int STAT_FAIL = 9;
   // Interrupt bits
   localparam int IRQ_HANDLE = 0;
   localparam int IRQ_QUIESCED = 1;
   localparam int IRQ_BOOT = 2;
   localparam int IRQ_CKFAIL = 3;
   localparam int IRQ_W = 4;
   localparam logic [3:0] IRQ_EN_RESET = 4'h0;
   // Timing
   localparam int CLK_HZ = 125_000_000;
   localparam int BLINK_PERIOD_MS = 1000;
   localparam int BLINK_CYCLES_DEF = CLK_HZ / 1000 * BLINK_PERIOD_MS;
   localparam int PCT_LONG = 90;
   localparam int PCT_FAST = 50;
   localparam int PCT_SHORT = 10;
   localparam int NUM_PORTS_DEF = 4;

   // Hot-swap states M1..M6, one-hot
   typedef enum logic [5:0] {
      HS_M1 = 6'h01, HS_M2 = 6'h02, HS_M3 = 6'h04,
      HS_M4 = 6'h08, HS_M5 = 6'h10, HS_M6 = 6'h20
   } mhs_hs_t;
   // Start-up sequence
   typedef enum logic [4:0] {
      BT_TEST = 5'h01, BT_CKSUM = 5'h02, BT_NOTIFY = 5'h04,
      BT_RUN = 5'h08, BT_FAIL = 5'h10
   } mhs_boot_t;
   // Indicator duty patterns
   typedef enum logic [2:0] {
      PAT_OFF, PAT_ON, PAT_LONG, PAT_FAST, PAT_SHORT
   } mhs_pat_t;
   // Avalon-MM request bundle
   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } mhs_avl_req_t;
   // Front-panel indicators
   typedef struct packed {
      logic blue;
      logic oos;
      logic hlt_green;
      logic hlt_amber;
   } mhs_led_t;
endpackage

// [rtl/mhs_sequencer.sv]
// Hot-swap sequencer, boot gate and front-panel indicator logic
`timescale 1ns/10ps
`default_nettype none

module mhs_sequencer #(
   parameter int BLINK_CYCLES = mhs_pkg::BLINK_CYCLES_DEF,
   parameter int NUM_PORTS = mhs_pkg::NUM_PORTS_DEF
) (
   input wire logic clk, // 125 MHz clock
   input wire logic arst_n, // Async reset, active low
   input wire mhs_pkg::mhs_avl_req_t avs_req, // Avalon request
   output logic [31:0] avs_readdata, // Avalon read data
   output logic avs_waitrequest, // Avalon wait
   output logic irq, // Level interrupt
   input wire logic handle_switch_n, // Handle switch, active low
   input wire logic payload_pwr_good, // Payload rails up
   input wire logic payload_in_reset, // Payload held in reset
   input wire logic selftest_ok, // Self-test result
   input wire logic cksum_valid, // Checksum result ready
   input wire logic cksum_ok, // Checksum matches
   input wire logic sup_restart, // Supervisor restart pulse
   input wire logic upgrade_manager_busy, // Manager self-update
   input wire logic fw_upgrade_active, // Upgrade or rollback
   input wire logic health_err, // Critical health error
   input wire logic hdd_act, // Disk activity
   output logic payload_pwr_en, // Payload power enable
   output logic evt_handle_open, // Handle-open event pulse
   output logic evt_quiesced, // Quiesced event pulse
   output logic upg_notify, // Notify upgrade manager pulse
   output logic ctrl_run, // Branch to operational code
   output logic ctrl_rst_hold, // Controller held in reset
   output logic [NUM_PORTS-1:0] port_en, // Port enables
   output mhs_pkg::mhs_led_t led // Indicator drives
);
   import mhs_pkg::*;

   localparam int PW = $clog2(BLINK_CYCLES);
   localparam int TH_LONG = BLINK_CYCLES / 100 * PCT_LONG;
   localparam int TH_FAST = BLINK_CYCLES / 100 * PCT_FAST;
   localparam int TH_SHORT = BLINK_CYCLES / 100 * PCT_SHORT;

   // Duty resolution needs at least a hundred steps per period
   if (BLINK_CYCLES < 100 || NUM_PORTS < 1 || NUM_PORTS > 32) begin
      $error("mhs_sequencer: unsupported parameter values");
   end

   // Pattern to LED level for the current phase
   function automatic logic pat_on(mhs_pat_t p, logic [PW-1:0] ph);
      logic r;
      r = 1'b0;
      unique case (p)
         PAT_OFF: r = 1'b0;
         PAT_ON: r = 1'b1;
         PAT_LONG: r = ph < PW'(TH_LONG);
         PAT_FAST: r = ph < PW'(TH_FAST);
         PAT_SHORT: r = ph < PW'(TH_SHORT);
      endcase
      return r;
   endfunction

   mhs_hs_t hs_ff, nxt_hs;
   mhs_boot_t boot_ff, nxt_boot;
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic [CTRL_W-1:0] ctrl_ff;
   logic [IRQ_W-1:0] irq_stat_ff, irq_en_ff, irq_set;
   logic [NUM_PORTS-1:0] port_ff;
   logic [PW-1:0] phase_ff;
   logic handle_prev_ff, pwr_ff, open_ff, quiesced_ff;
   logic notify_ff, run_ff, hold_ff;
   mhs_led_t led_ff;
   mhs_pat_t blue_pat, oos_pat;
   logic wr_acc, handle_fell;
   logic cmd_quiesce, cmd_reject, cmd_act_req, cmd_act_grant;

   // One wait cycle per access: data is latched first, then accepted
   assign avs_waitrequest = (avs_req.read | avs_req.write) & ~ack_ff;
   assign wr_acc = avs_req.write & ack_ff;
   assign cmd_quiesce = wr_acc && avs_req.address == REG_CMD
      && avs_req.writedata[CMD_QUIESCE];
   assign cmd_reject = wr_acc && avs_req.address == REG_CMD
      && avs_req.writedata[CMD_REJECT];
   assign cmd_act_req = wr_acc && avs_req.address == REG_CMD
      && avs_req.writedata[CMD_ACT_REQ];
   assign cmd_act_grant = wr_acc && avs_req.address == REG_CMD
      && avs_req.writedata[CMD_ACT_GRANT];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_req.read | avs_req.write) & ~ack_ff;
      end
   end

   // Read mux; unmapped addresses and write-only registers read zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_req.read && !ack_ff) begin
         rdata_ff <= 32'h0000_0000;
         unique case (avs_req.address)
            REG_CTRL: rdata_ff[CTRL_W-1:0] <= ctrl_ff;
            REG_STATUS: begin
               rdata_ff[STAT_HS_LSB +: 6] <= hs_ff;
               rdata_ff[STAT_PWR] <= pwr_ff;
               rdata_ff[STAT_RUN] <= run_ff;
               rdata_ff[STAT_HOLD] <= hold_ff;
               rdata_ff[STAT_FAIL] <= boot_ff == BT_FAIL;
            end
            REG_IRQ_STAT: rdata_ff[IRQ_W-1:0] <= irq_stat_ff;
            REG_IRQ_EN: rdata_ff[IRQ_W-1:0] <= irq_en_ff;
            REG_PORT: rdata_ff[NUM_PORTS-1:0] <= port_ff;
            default: rdata_ff <= 32'h0000_0000;
         endcase
      end
   end
   assign avs_readdata = rdata_ff;

   // Software-written control and port state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_ff <= CTRL_RESET;
         irq_en_ff <= IRQ_EN_RESET;
         port_ff <= '0;
      end else if (wr_acc) begin
         if (avs_req.address == REG_CTRL) begin
            ctrl_ff <= avs_req.writedata[CTRL_W-1:0];
         end
         if (avs_req.address == REG_IRQ_EN) begin
            irq_en_ff <= avs_req.writedata[IRQ_W-1:0];
         end
         if (avs_req.address == REG_PORT) begin
            port_ff <= avs_req.writedata[NUM_PORTS-1:0];
         end
      end
   end
   assign port_en = port_ff;

   // Sticky events; a new event wins over a clear in the same cycle
   assign irq_set = {nxt_boot == BT_FAIL && boot_ff != BT_FAIL,
      boot_ff == BT_NOTIFY, hs_ff == HS_M6 && nxt_hs == HS_M1,
      handle_fell && hs_ff == HS_M4};
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat_ff <= '0;
      end else if (wr_acc && avs_req.address == REG_IRQ_CLR) begin
         irq_stat_ff <= (irq_stat_ff & ~avs_req.writedata[IRQ_W-1:0])
            | irq_set;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_set;
      end
   end
   assign irq = |(irq_stat_ff & irq_en_ff);

   // Handle switch edge; the idle level is released (high)
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         handle_prev_ff <= 1'b1;
      end else begin
         handle_prev_ff <= handle_switch_n;
      end
   end
   assign handle_fell = handle_prev_ff & ~handle_switch_n;

   // Hot-swap sequence; carrier decisions arrive as commands
   always_comb begin
      nxt_hs = hs_ff;
      unique case (hs_ff)
         HS_M1: if (cmd_act_req) nxt_hs = HS_M2;
         HS_M2: if (cmd_act_grant) nxt_hs = HS_M3;
         HS_M3: if (payload_pwr_good) nxt_hs = HS_M4;
         HS_M4: if (handle_fell) nxt_hs = HS_M5;
         HS_M5: begin
            if (cmd_quiesce) nxt_hs = HS_M6;
            else if (cmd_reject) nxt_hs = HS_M4;
         end
         HS_M6: if (!pwr_ff && !payload_pwr_good) nxt_hs = HS_M1;
         default: nxt_hs = HS_M1;
      endcase
   end

   // A supervisor restart does not touch this state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hs_ff <= HS_M1;
      end else begin
         hs_ff <= nxt_hs;
      end
   end

   // Payload power follows the sequence, never the boot path
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pwr_ff <= 1'b0;
      end else if (hs_ff == HS_M2 && cmd_act_grant) begin
         pwr_ff <= 1'b1;
      end else if (hs_ff == HS_M5 && cmd_quiesce) begin
         pwr_ff <= 1'b0;
      end
   end
   assign payload_pwr_en = pwr_ff;

   // Event pulses towards the carrier message path
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         open_ff <= 1'b0;
         quiesced_ff <= 1'b0;
      end else begin
         open_ff <= hs_ff == HS_M4 && handle_fell;
         quiesced_ff <= hs_ff == HS_M6 && nxt_hs == HS_M1;
      end
   end
   assign evt_handle_open = open_ff;
   assign evt_quiesced = quiesced_ff;

   // Start-up gate; the checksum must verify before running
   always_comb begin
      nxt_boot = boot_ff;
      unique case (boot_ff)
         BT_TEST: nxt_boot = selftest_ok ? BT_CKSUM : BT_FAIL;
         BT_CKSUM: begin
            if (cksum_valid) nxt_boot = cksum_ok ? BT_NOTIFY : BT_FAIL;
         end
         BT_NOTIFY: nxt_boot = BT_RUN;
         BT_RUN: nxt_boot = BT_RUN;
         BT_FAIL: nxt_boot = BT_FAIL;
         default: nxt_boot = BT_TEST;
      endcase
      if (upgrade_manager_busy || sup_restart) begin
         nxt_boot = BT_TEST;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         boot_ff <= BT_TEST;
         notify_ff <= 1'b0;
         run_ff <= 1'b0;
         hold_ff <= 1'b0;
      end else begin
         boot_ff <= nxt_boot;
         notify_ff <= boot_ff == BT_NOTIFY;
         run_ff <= nxt_boot == BT_RUN;
         hold_ff <= upgrade_manager_busy;
      end
   end
   assign upg_notify = notify_ff;
   assign ctrl_run = run_ff;
   assign ctrl_rst_hold = hold_ff;

   // Common blink phase so all indicators share one period
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_ff <= '0;
      end else if (phase_ff == PW'(BLINK_CYCLES - 1)) begin
         phase_ff <= '0;
      end else begin
         phase_ff <= phase_ff + 1'b1;
      end
   end

   // Pattern selection per indicator
   always_comb begin
      blue_pat = PAT_OFF;
      unique case (hs_ff)
         HS_M1: blue_pat = PAT_ON;
         HS_M2, HS_M3: blue_pat = PAT_LONG;
         HS_M4: blue_pat = PAT_OFF;
         HS_M5, HS_M6: blue_pat = PAT_SHORT;
         default: blue_pat = PAT_OFF;
      endcase
      // State patterns outrank the software value
      if (hold_ff) oos_pat = PAT_ON;
      else if (fw_upgrade_active) oos_pat = PAT_FAST;
      else if (ctrl_ff[CTRL_PWR_DENIED]) oos_pat = PAT_SHORT;
      else if (ctrl_ff[CTRL_OOS_APP_EN])
         oos_pat = ctrl_ff[CTRL_OOS_APP_ON] ? PAT_ON : PAT_OFF;
      else oos_pat = PAT_OFF;
   end

   // Registered indicator drive; disk activity blanks health at half duty
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         led_ff <= '0;
      end else begin
         led_ff.blue <= pat_on(blue_pat, phase_ff);
         led_ff.oos <= pat_on(oos_pat, phase_ff);
         if (hdd_act && !pat_on(PAT_FAST, phase_ff)) begin
            led_ff.hlt_green <= 1'b0;
            led_ff.hlt_amber <= 1'b0;
         end else if (ctrl_ff[CTRL_HLT_APP_EN]) begin
            led_ff.hlt_amber <= ctrl_ff[CTRL_HLT_APP_AMBER];
            led_ff.hlt_green <= ~ctrl_ff[CTRL_HLT_APP_AMBER];
         end else if (health_err || !pwr_ff || payload_in_reset) begin
            led_ff.hlt_amber <= 1'b1;
            led_ff.hlt_green <= 1'b0;
         end else begin
            led_ff.hlt_amber <= 1'b0;
            led_ff.hlt_green <= 1'b1;
         end
      end
   end
   assign led = led_ff;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_quiesce_req;
      hs_ff == HS_M5 && cmd_quiesce;
   endsequence
   sequence s_power_off_m6;
      !payload_pwr_en && hs_ff == HS_M6;
   endsequence

   a_handle_open_evt: assert property (
      hs_ff == HS_M4 && handle_fell |=> evt_handle_open && hs_ff == HS_M5)
      else $error("handle open not reported");
   a_quiesce_power: assert property (
      s_quiesce_req |=> s_power_off_m6)
      else $error("quiesce did not drop payload power");
   a_quiesced_evt: assert property (
      hs_ff == HS_M6 && !payload_pwr_en && !payload_pwr_good
      |=> hs_ff == HS_M1 && evt_quiesced)
      else $error("quiesced event missing");
   a_reject_off: assert property (
      hs_ff == HS_M5 && cmd_reject && !cmd_quiesce
      |=> hs_ff == HS_M4 ##1 !led.blue)
      else $error("reject did not turn blue off");
   a_m6_pattern: assert property (
      hs_ff == HS_M6 |-> ##1 led.blue == (phase_ff != '0
      && $past(phase_ff) < PW'(TH_SHORT)))
      else $error("blue pattern wrong in M6");
   a_blue_solid: assert property (
      hs_ff == HS_M1 |=> led.blue)
      else $error("blue not solid when inactive");
   a_oos_hold: assert property (
      upgrade_manager_busy |=> ctrl_rst_hold ##1 led.oos)
      else $error("out-of-service not solid in reset");
   a_health_amber: assert property (
      !payload_pwr_en && !hdd_act && !ctrl_ff[CTRL_HLT_APP_EN]
      |=> led.hlt_amber && !led.hlt_green)
      else $error("health not amber with payload off");
   a_boot_gate: assert property (
      $rose(ctrl_run) |-> $past(boot_ff) == BT_NOTIFY && upg_notify)
      else $error("ran without verified checksum");
   a_upg_hold: assert property (
      upgrade_manager_busy |=> !ctrl_run && ctrl_rst_hold)
      else $error("controller not held during update");
   a_port_state: assert property (
      wr_acc && avs_req.address == REG_PORT
      |=> port_en == $past(avs_req.writedata[NUM_PORTS-1:0]))
      else $error("port enables not updated");
   a_restart_keep: assert property (
      sup_restart && !(hs_ff == HS_M2 && cmd_act_grant) && !cmd_quiesce
      |=> payload_pwr_en == $past(payload_pwr_en))
      else $error("restart disturbed payload power");
   a_phase_wrap: assert property (
      phase_ff == PW'(BLINK_CYCLES - 1) |=> phase_ff == '0)
      else $error("blink phase did not wrap");
   a_bus_answer: assert property (
      avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held too long");
endmodule

`default_nettype wire

// [verif/mhs_payload_model.sv]
// Payload power supply model that answers the block's power enable
`timescale 1ns/10ps
`default_nettype none
module mhs_payload_model #(
   parameter int UP_DLY = 10,
   parameter int DN_DLY = 600
) (
   input wire logic clk, // Controller clock
   input wire logic arst_n, // Async reset, active low
   input wire logic pwr_en, // Power enable from the block
   output logic pwr_good // Rails in regulation
);
   int cnt;
   // Rails ramp both ways; the slow fall keeps the quiesce window visible
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt <= 0;
         pwr_good <= 1'b0;
      end else if (pwr_en === pwr_good) begin
         cnt <= 0;
      end else if (cnt >= (pwr_en ? UP_DLY : DN_DLY)) begin
         pwr_good <= pwr_en;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule
`default_nettype wire

// [verif/mhs_sequencer_tb_top.sv]
// Self-checking bench for the hot-swap sequencer and indicators
`timescale 1ns/10ps
`default_nettype none
module mhs_sequencer_tb_top;
   import mhs_pkg::*;
   localparam int BC = 200;
   logic clk, arst_n, avs_waitrequest, irq, handle_switch_n;
   logic payload_pwr_good, payload_in_reset, selftest_ok, cksum_valid;
   logic cksum_ok, sup_restart, upgrade_manager_busy, fw_upgrade_active;
   logic health_err, hdd_act, payload_pwr_en, evt_handle_open, evt_quiesced;
   logic upg_notify, ctrl_run, ctrl_rst_hold;
   logic [3:0] port_en, led_v;
   logic [31:0] avs_readdata, q, pv;
   mhs_avl_req_t avs_req;
   mhs_led_t led;
   int err_count = 0, total_checks = 0, seed = 33;
   int n_ho = 0, n_qu = 0, n_note = 0;
   int m_hs = 1, m_pwr = 0, m_run = 0, m_hold = 0, m_fail = 0, m_irq = 0;
   assign led_v = led;

   mhs_sequencer #(.BLINK_CYCLES(BC), .NUM_PORTS(4)) uut (.clk(clk),
      .arst_n(arst_n), .avs_req(avs_req), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .irq(irq),
      .handle_switch_n(handle_switch_n), .payload_pwr_good(payload_pwr_good),
      .payload_in_reset(payload_in_reset), .selftest_ok(selftest_ok),
      .cksum_valid(cksum_valid), .cksum_ok(cksum_ok),
      .sup_restart(sup_restart), .upgrade_manager_busy(upgrade_manager_busy),
      .fw_upgrade_active(fw_upgrade_active), .health_err(health_err),
      .hdd_act(hdd_act), .payload_pwr_en(payload_pwr_en),
      .evt_handle_open(evt_handle_open), .evt_quiesced(evt_quiesced),
      .upg_notify(upg_notify), .ctrl_run(ctrl_run),
      .ctrl_rst_hold(ctrl_rst_hold), .port_en(port_en), .led(led));

   mhs_payload_model #(.UP_DLY(10), .DN_DLY(600)) supply (.clk(clk),
      .arst_n(arst_n), .pwr_en(payload_pwr_en), .pwr_good(payload_pwr_good));

   // Clock at 125 MHz
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Pulses are counted per cycle high, so a stretched pulse shows up
   always @(posedge clk) begin
      n_ho <= n_ho + int'(evt_handle_open);
      n_qu <= n_qu + int'(evt_quiesced);
      n_note <= n_note + int'(upg_notify);
   end

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      tally_and_finish();
   end

   task tally_and_finish;
      $display("Checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One Avalon access; request held until waitrequest is seen low
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
            output logic [31:0] rq);
      int i;
      @(posedge clk);
      avs_req <= '{address: a, read: !wr, write: wr, writedata: d};
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 20);
      if (i >= 20) begin
         err_count++;
         tally_and_finish();
      end
      rq = avs_readdata;
      avs_req <= '0;
   endtask

   task wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task rd(input logic [4:0] a, output logic [31:0] rq);
      bus(1'b0, a, 32'h0, rq);
   endtask

   // Model of the status word built from the tracked state
   function automatic logic [31:0] exp_stat();
      return 32'((m_fail << 9) | (m_hold << 8) | (m_run << 7) |
                 (m_pwr << 6) | m_hs);
   endfunction

   // Polls status until it matches the model, bounded
   task wait_stat;
      logic [31:0] s, e;
      int i;
      e = exp_stat();
      i = 0;
      do begin
         rd(REG_STATUS, s);
         i++;
      end while (s !== e && i < 500);
      chk(s, e);
      if (s !== e) tally_and_finish();
   endtask

   // High cycles of one indicator over one blink period
   task duty(input int b, input int exp);
      int n;
      n = 0;
      repeat (3) @(negedge clk);
      repeat (BC) begin
         @(negedge clk);
         n += int'(led_v[b]);
      end
      // Return on a rising edge so the next stimulus is driven there
      @(posedge clk);
      chk(32'(n), 32'(exp));
   endtask

   task pulse_restart;
      @(posedge clk);
      sup_restart <= 1'b1;
      @(posedge clk);
      sup_restart <= 1'b0;
   endtask

   // Main sequence; the bench plays the carrier through command writes
   initial begin
      avs_req = '0;
      handle_switch_n = 1'b1;
      payload_in_reset = 1'b0;
      selftest_ok = 1'b1;
      cksum_valid = 1'b1;
      cksum_ok = 1'b1;
      sup_restart = 1'b0;
      upgrade_manager_busy = 1'b0;
      fw_upgrade_active = 1'b0;
      health_err = 1'b0;
      hdd_act = 1'b0;
      arst_n = 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      m_run = 1;
      m_irq = 4;
      wait_stat();
      chk(n_note, 1);
      rd(REG_CTRL, q);
      chk(q, 32'h0);
      rd(REG_IRQ_EN, q);
      chk(q, 32'h0);
      wr(5'h1c, 32'hffff_ffff);
      rd(5'h1c, q);
      chk(q, 32'h0);
      duty(3, BC);
      duty(0, BC);
      $display("Test reset done");
      wr(REG_CMD, 32'h1 << CMD_ACT_REQ);
      m_hs = 2;
      wait_stat();
      duty(3, BC * 90 / 100);
      wr(REG_CMD, 32'h1 << CMD_ACT_GRANT);
      m_hs = 8;
      m_pwr = 1;
      wait_stat();
      duty(3, 0);
      duty(1, BC);
      $display("Test activation done");
      hdd_act <= 1'b1;
      duty(1, BC / 2);
      hdd_act <= 1'b0;
      health_err <= 1'b1;
      duty(0, BC);
      health_err <= 1'b0;
      payload_in_reset <= 1'b1;
      duty(0, BC);
      payload_in_reset <= 1'b0;
      wr(REG_CTRL, 32'h0c);
      duty(0, BC);
      wr(REG_CTRL, 32'h10);
      duty(2, BC / 10);
      wr(REG_CTRL, 32'h03);
      duty(2, BC);
      wr(REG_CTRL, 32'h01);
      duty(2, 0);
      wr(REG_CTRL, 32'h00);
      // Upgrade manager is updated before the controller itself
      upgrade_manager_busy <= 1'b1;
      duty(2, BC);
      chk(ctrl_rst_hold, 1);
      m_hold = 1;
      m_run = 0;
      wait_stat();
      upgrade_manager_busy <= 1'b0;
      m_hold = 0;
      m_run = 1;
      wait_stat();
      chk(n_note, 2);
      fw_upgrade_active <= 1'b1;
      duty(2, BC / 2);
      fw_upgrade_active <= 1'b0;
      $display("Test indicators done");
      cksum_ok <= 1'b0;
      pulse_restart();
      m_run = 0;
      m_fail = 1;
      m_irq = 12;
      wait_stat();
      chk(ctrl_run, 0);
      cksum_ok <= 1'b1;
      pulse_restart();
      m_run = 1;
      m_fail = 0;
      wait_stat();
      $display("Test boot done");
      rd(REG_IRQ_STAT, q);
      chk(q, 32'(m_irq));
      // The enable lands at the completing edge; look one edge later
      wr(REG_IRQ_EN, 32'h1 << IRQ_CKFAIL);
      @(posedge clk);
      chk(irq, 1);
      wr(REG_IRQ_EN, 32'h1 << IRQ_HANDLE);
      @(posedge clk);
      chk(irq, 0);
      wr(REG_IRQ_CLR, 32'hf);
      m_irq = 0;
      rd(REG_IRQ_STAT, q);
      chk(q, 32'h0);
      rd(REG_CMD, q);
      chk(q, 32'h0);
      handle_switch_n <= 1'b0;
      m_hs = 16;
      m_irq = 1;
      wait_stat();
      chk(n_ho, 1);
      chk(irq, 1);
      duty(3, BC / 10);
      wr(REG_CMD, 32'h1 << CMD_REJECT);
      m_hs = 8;
      wait_stat();
      duty(3, 0);
      handle_switch_n <= 1'b1;
      repeat (4) @(posedge clk);
      handle_switch_n <= 1'b0;
      m_hs = 16;
      wait_stat();
      chk(n_ho, 2);
      wr(REG_CMD, 32'h1 << CMD_QUIESCE);
      m_hs = 32;
      m_pwr = 0;
      wait_stat();
      chk(payload_pwr_en, 0);
      duty(3, BC / 10);
      m_hs = 1;
      m_irq = 3;
      wait_stat();
      chk(n_qu, 1);
      duty(3, BC);
      rd(REG_IRQ_STAT, q);
      chk(q, 32'(m_irq));
      $display("Test hot swap done");
      repeat (4) begin
         pv = $random(seed);
         wr(REG_PORT, pv);
         rd(REG_PORT, q);
         chk(port_en, pv[3:0]);
         chk(q, {28'h0, pv[3:0]});
      end
      $display("Test ports done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
